// >>> hw/uils_line_status.sv
// Purpose: interrupt status summary and receive line status of one uart channel
// Assumes: fifo storage, receiver and irq enable register live outside
// Notes:   rhr reads arrive on the register port and pop the receive fifo outside
//
// Contract
// - status register clears on read; resets 0x60
// - bit 7 sets on any cts change
// - bit 6 rx empty, mode-invertible
// - bit 5 sets when tx fifo empties
// - bit 4 tx level at trigger; clears below
// - bit 3 rx level reaches trigger, invertible
// - bit 2 from enabled secondary status bits
// - bit 1 special char, break, address
// - bit 0 from enabled line flags
// - line enable bits 5:0 route flags; reset zero
// - line flags describe last read character
// - line status bit 7 follows cts level
// - noise tag shows in bit 5
// - break char tag shows in bit 4
// - missing stop bits show in bit 3
// - parity error, or ninth bit in multidrop
// - full fifo drops new char, bit 1
// - stale data timeout sets bit 0
// - zero timeout period disables timeout
// - irq enables never alter status register
`timescale 1ns/1ps

module uils_line_status
  import uils_pkg::*;
#(
  parameter int LEVEL_W    = 8,
  parameter int TRIG_SHIFT = 3
)
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   clkEn,
  // register port
  input  wire logic [7:0]             regAddr,
  input  wire logic                   regRd,
  input  wire logic                   regWr,
  input  wire logic [7:0]             regWdata,
  output logic      [7:0]             regRdata,
  // configuration from other registers
  input  wire logic [7:0]             irqEnable,
  input  wire logic [7:0]             triggerLevel,
  input  wire logic [7:0]             timeoutPeriod,
  input  wire logic                   rxEmptyInvert,
  input  wire logic                   rxTrigInvert,
  input  wire logic                   multidropMode,
  // fifo and receiver state
  input  wire logic [LEVEL_W-1:0]     rxLevel,
  input  wire logic [LEVEL_W-1:0]     txLevel,
  input  wire logic                   rxFull,
  input  wire logic                   rxCharValid,
  input  wire uils_char_flags_s       headFlags,
  input  wire logic                   timeoutTick,
  input  wire logic                   secondaryPending,
  input  wire logic                   specialCharEvent,
  // pins
  input  wire logic                   ctsPin,
  output logic                        irqN
);

  function automatic logic atTrigger(input logic [LEVEL_W-1:0] lvl,
                                     input logic [TRIG_BITS-1:0] nib);
    logic [LEVEL_W+TRIG_BITS+TRIG_SHIFT-1:0] thr;
    thr = '0;
    thr[TRIG_SHIFT +: TRIG_BITS] = nib;
    atTrigger = ({{(TRIG_BITS+TRIG_SHIFT){1'b0}}, lvl} >= thr);
  endfunction

  // cts synchroniser; first stage is read only by the second
  logic ctsMeta_ff, ctsSync_ff, ctsLast_ff;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctsMeta_ff <= 1'b0;
      ctsSync_ff <= 1'b0;
      ctsLast_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      ctsMeta_ff <= ctsPin;
      ctsSync_ff <= ctsMeta_ff;
      ctsLast_ff <= ctsSync_ff;
    end
  end

  logic rhrRead, isrRead, lieWrite, overflowEvent;
  assign rhrRead       = regRd && (regAddr == ADDR_RECEIVE_HOLDING);
  assign isrRead       = regRd && (regAddr == ADDR_INTERRUPT_STATUS);
  assign lieWrite      = regWr && (regAddr == ADDR_LINE_INT_ENABLE);
  assign overflowEvent = rxCharValid && rxFull;

  // registers and line flags
  logic [7:0] lineIntEn_ff, nxt_lineIntEn;
  logic [4:0] charErr_ff, nxt_charErr;
  logic       overflow_ff, nxt_overflow;
  logic [8:0] staleCnt_ff, nxt_staleCnt;
  logic       stale_ff, nxt_stale;
  logic [7:0] lineStatus;

  always_comb
  begin
    nxt_lineIntEn = lineIntEn_ff;
    nxt_charErr   = charErr_ff;
    nxt_overflow  = overflow_ff;
    nxt_staleCnt  = staleCnt_ff;
    nxt_stale     = stale_ff;
    // only bits 5:0 hold a value
    if (lieWrite)
      nxt_lineIntEn = regWdata & LINE_INT_ENABLE_MASK;
    // flags reload only when a character is read
    if (rhrRead)
    begin
      // tags of the character being read
      nxt_charErr[4] = headFlags.noise;
      nxt_charErr[3] = headFlags.brk;
      nxt_charErr[2] = headFlags.framing;
      // ninth bit replaces parity in multidrop
      nxt_charErr[1] = multidropMode ? headFlags.ninthBit : headFlags.parity;
      nxt_charErr[0] = 1'b0;
      nxt_overflow   = 1'b0;
    end
    // set wins over the read clear
    if (overflowEvent)
      nxt_overflow = 1'b1;
    if (rhrRead || (rxCharValid && !rxFull))
    begin
      nxt_staleCnt = '0;
      nxt_stale    = 1'b0;
    end
    else if (timeoutTick && (rxLevel != '0) && (staleCnt_ff != 9'h1ff))
      nxt_staleCnt = staleCnt_ff + 9'h001;
    if (!(rhrRead || (rxCharValid && !rxFull)) && (timeoutPeriod != 8'h00)
        && (staleCnt_ff > {1'b0, timeoutPeriod}))
      nxt_stale = 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      lineIntEn_ff <= LINE_INT_ENABLE_RST;
      charErr_ff   <= 5'h00;
      overflow_ff  <= 1'b0;
      staleCnt_ff  <= 9'h000;
      stale_ff     <= 1'b0;
    end
    else if (clkEn)
    begin
      lineIntEn_ff <= nxt_lineIntEn;
      charErr_ff   <= nxt_charErr;
      overflow_ff  <= nxt_overflow;
      staleCnt_ff  <= nxt_staleCnt;
      stale_ff     <= nxt_stale;
    end
  end

  // cts level in bit 7, bit 6 reads zero
  assign lineStatus = {ctsSync_ff, 1'b0, charErr_ff[4:1], overflow_ff, stale_ff};

  // interrupt status conditions; edge-detected so a read really clears them
  logic [7:0] cond, condLast_ff, nxt_condLast;
  logic [7:0] isr_ff, nxt_isr;
  logic       txTrig;
  logic [5:0] lineEnabled, lineLast_ff, nxt_lineLast;
  assign txTrig = atTrigger(txLevel, triggerLevel[TRIG_TX_LSB +: TRIG_BITS]);
  // routed flags are edge-detected one by one, so a new flag counts even if another stands
  assign lineEnabled = lineStatus[5:0] & lineIntEn_ff[5:0];

  always_comb
  begin
    cond = 8'h00;
    cond[IS_CTS_CHANGE] = 1'b0;
    cond[IS_RX_EMPTY]   = (rxLevel == '0) ^ rxEmptyInvert;
    cond[IS_TX_EMPTY]   = (txLevel == '0);
    cond[IS_TX_LEVEL]   = txTrig;
    cond[IS_RX_LEVEL]   = atTrigger(rxLevel, triggerLevel[TRIG_RX_LSB +: TRIG_BITS])
                          ^ rxTrigInvert;
    // secondary already masked by its own enables
    cond[IS_SECONDARY]  = secondaryPending;
    cond[IS_SPECIAL]    = 1'b0;
    cond[IS_LINE_ERROR] = |lineEnabled;
  end

  logic [7:0] isrSet;
  always_comb
  begin
    nxt_condLast = cond;
    nxt_lineLast = lineEnabled;
    isrSet = cond & ~condLast_ff;
    // any routed flag that becomes active
    isrSet[IS_LINE_ERROR] = |(lineEnabled & ~lineLast_ff);
    isrSet[IS_CTS_CHANGE] = ctsSync_ff ^ ctsLast_ff;
    // pulse from the special character logic
    isrSet[IS_SPECIAL]    = specialCharEvent;
    nxt_isr = isr_ff;
    if (isrRead)
      nxt_isr = 8'h00;
    // clears when fill drops below trigger
    if (!txTrig)
      nxt_isr[IS_TX_LEVEL] = 1'b0;
    nxt_isr = nxt_isr | isrSet;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      condLast_ff <= COND_HISTORY_RST;
      lineLast_ff <= 6'h00;
      isr_ff      <= INTERRUPT_STATUS_RST;
    end
    else if (clkEn)
    begin
      condLast_ff <= nxt_condLast;
      lineLast_ff <= nxt_lineLast;
      isr_ff      <= nxt_isr;
    end
  end

  // read data and interrupt pin
  logic [7:0] regRdata_ff, nxt_regRdata;
  logic       irqN_ff, nxt_irqN;

  always_comb
  begin
    nxt_regRdata = regRdata_ff;
    if (regRd)
    begin
      case (regAddr)
        ADDR_INTERRUPT_STATUS: nxt_regRdata = isr_ff;
        ADDR_LINE_INT_ENABLE:  nxt_regRdata = lineIntEn_ff;
        ADDR_LINE_STATUS:      nxt_regRdata = lineStatus;
        default:               nxt_regRdata = 8'h00;
      endcase
    end
    nxt_irqN = ~|(nxt_isr & irqEnable);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      regRdata_ff <= 8'h00;
      irqN_ff     <= 1'b1;
    end
    else if (clkEn)
    begin
      regRdata_ff <= nxt_regRdata;
      irqN_ff     <= nxt_irqN;
    end
  end

  assign regRdata = regRdata_ff;
  assign irqN     = irqN_ff;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_isr_read_clear: assert property (clkEn && isrRead && (isrSet == 8'h00) && txTrig
                                     |=> isr_ff == 8'h00)
    else $error("status not cleared by read");
  a_read_returns_isr: assert property (clkEn && isrRead |=> regRdata == $past(isr_ff))
    else $error("status read data wrong");
  a_cts_edge_sets: assert property (clkEn && (ctsSync_ff != ctsLast_ff)
                                    |=> isr_ff[IS_CTS_CHANGE])
    else $error("cts change missed");
  a_tx_level_drop: assert property (clkEn && !txTrig |=> !isr_ff[IS_TX_LEVEL])
    else $error("tx level bit stayed set");
  a_special_sets: assert property (clkEn && specialCharEvent |=> isr_ff[IS_SPECIAL])
    else $error("special event missed");
  a_lie_reserved: assert property (lineIntEn_ff[7:6] == 2'b00)
    else $error("reserved enable bits set");
  a_flags_hold: assert property (clkEn && !rhrRead && !overflowEvent
                                 |=> $stable(charErr_ff) && (overflow_ff == $past(overflow_ff)))
    else $error("line flags changed without read");
  a_parity_multidrop: assert property (clkEn && rhrRead && multidropMode
                                       |=> lineStatus[LS_PARITY] == $past(headFlags.ninthBit))
    else $error("ninth bit not reported");
  a_overflow_sets: assert property (clkEn && overflowEvent |=> lineStatus[LS_OVERFLOW])
    else $error("overflow missed");
  a_timeout_off: assert property (timeoutPeriod == 8'h00 |=> !$rose(stale_ff))
    else $error("timeout with zero period");
  a_irq_pin: assert property (clkEn |=> irqN == !(|(isr_ff & $past(irqEnable))))
    else $error("irq pin mismatch");
  a_cts_level: assert property (clkEn |-> ##2 lineStatus[LS_CTS_LEVEL] == $past(ctsPin, 2)
                                || !$past(clkEn) || !$past(clkEn, 2))
    else $error("cts level wrong");

  c_timeout_hit: cover property (clkEn && nxt_stale && !stale_ff);
  c_overflow_hit: cover property (clkEn && overflowEvent);
  c_isr_read_set: cover property (clkEn && isrRead && (isrSet != 8'h00));
  c_irq_low: cover property (!irqN);

endmodule // uils_line_status

// >>> hw/uils_pkg.sv
// Purpose: shared constants and types for the uart interrupt / line status block
// Assumes: 8-bit register port, one channel
// Notes:   bit positions are those seen by software in each register
package uils_pkg;

  // register offsets on the register port
  localparam logic [7:0] ADDR_RECEIVE_HOLDING  = 8'h00;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h02;
  localparam logic [7:0] ADDR_LINE_INT_ENABLE  = 8'h03;
  localparam logic [7:0] ADDR_LINE_STATUS      = 8'h04;

  // interrupt status bit positions
  localparam int IS_CTS_CHANGE  = 7;
  localparam int IS_RX_EMPTY    = 6;
  localparam int IS_TX_EMPTY    = 5;
  localparam int IS_TX_LEVEL    = 4;
  localparam int IS_RX_LEVEL    = 3;
  localparam int IS_SECONDARY   = 2;
  localparam int IS_SPECIAL     = 1;
  localparam int IS_LINE_ERROR  = 0;

  // line status bit positions (same positions in the line enable register)
  localparam int LS_CTS_LEVEL   = 7;
  localparam int LS_NOISE       = 5;
  localparam int LS_BREAK       = 4;
  localparam int LS_FRAMING     = 3;
  localparam int LS_PARITY      = 2;
  localparam int LS_OVERFLOW    = 1;
  localparam int LS_TIMEOUT     = 0;

  // reset values and writable masks
  localparam logic [7:0] INTERRUPT_STATUS_RST = 8'h60;
  localparam logic [7:0] LINE_INT_ENABLE_RST  = 8'h00;
  localparam logic [7:0] LINE_INT_ENABLE_MASK = 8'h3f;
  localparam logic [7:0] COND_HISTORY_RST     = 8'h60;

  // trigger field positions inside trigger_level_reg
  localparam int TRIG_TX_LSB = 0;
  localparam int TRIG_RX_LSB = 4;
  localparam int TRIG_BITS   = 4;

  // error tags carried by each received character
  typedef struct packed {
    logic noise;
    logic brk;
    logic framing;
    logic parity;
    logic ninthBit;
  } uils_char_flags_s;

endpackage

// >>> verification/tb_uart_interrupt_line_status.sv
// Purpose: self-checking bench for the interrupt / line status block
// Assumes: fifo, receiver and irq enable register modelled by bench inputs
// Notes:   read results go through a queue, checked just after the edge that takes the strobe
`timescale 1ns/1ps

module tb_uart_interrupt_line_status
  import uils_pkg::*;
;
  logic             mclk, resetn, clkEn, regRd, regWr, rxEmptyInvert, rxTrigInvert;
  logic             multidropMode, rxFull, rxCharValid, timeoutTick, secondaryPending;
  logic             specialCharEvent, ctsPin, irqN;
  logic [7:0]       regAddr, regWdata, regRdata, irqEnable, triggerLevel, timeoutPeriod;
  logic [7:0]       rxLevel, txLevel;
  uils_char_flags_s headFlags, f;
  logic [7:0]       expQ[$];
  int               error_cnt, n_tests;

  uils_line_status dut (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
    .regRd(regRd), .regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
    .irqEnable(irqEnable), .triggerLevel(triggerLevel), .timeoutPeriod(timeoutPeriod),
    .rxEmptyInvert(rxEmptyInvert), .rxTrigInvert(rxTrigInvert),
    .multidropMode(multidropMode), .rxLevel(rxLevel), .txLevel(txLevel), .rxFull(rxFull),
    .rxCharValid(rxCharValid), .headFlags(headFlags), .timeoutTick(timeoutTick),
    .secondaryPending(secondaryPending), .specialCharEvent(specialCharEvent),
    .ctsPin(ctsPin), .irqN(irqN));
  uils_host_model host (.mclk(mclk), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
    .regWdata(regWdata));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      tick(1);
      timeoutTick <= 1'b1;
      tick(1);
      timeoutTick <= 1'b0;
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // read data lands on the same edge that takes the strobe
  always @(posedge mclk)
    if (regRd === 1'b1)
    begin
      #1;
      chk("regRdata", expQ.pop_front(), regRdata);
    end

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    tick(5000);
    error_cnt++;
    summarize();
  end

  initial
  begin
    {resetn, rxEmptyInvert, rxTrigInvert, multidropMode, rxFull} = '0;
    {rxCharValid, timeoutTick, secondaryPending, specialCharEvent, ctsPin} = '0;
    {irqEnable, timeoutPeriod, rxLevel, txLevel} = '0;
    clkEn = 1'b1;
    triggerLevel = 8'hff;
    headFlags = '0;
    void'($urandom(86));
    tick(12);
    resetn <= 1'b1;
    rx(ADDR_INTERRUPT_STATUS, INTERRUPT_STATUS_RST);
    rx(ADDR_INTERRUPT_STATUS, 8'h00);
    rx(ADDR_LINE_INT_ENABLE, LINE_INT_ENABLE_RST);
    rx(ADDR_LINE_STATUS, 8'h00);
    rx(8'h7e, 8'h00);
    host.wr(ADDR_LINE_INT_ENABLE, 8'hff);
    rx(ADDR_LINE_INT_ENABLE, LINE_INT_ENABLE_MASK);
    ctsPin <= 1'b1;
    tick(5);
    rx(ADDR_LINE_STATUS, 8'h80);
    rx(ADDR_INTERRUPT_STATUS, 8'h80);
    $display("test registers_cts done");
    for (int i = 0; i < 8; i++)
    begin
      f = 5'($urandom);
      multidropMode <= i[0];
      headFlags <= f;
      rx(ADDR_RECEIVE_HOLDING, 8'h00);
      rx(ADDR_LINE_STATUS, {2'b10, f.noise, f.brk, f.framing,
        i[0] ? f.ninthBit : f.parity, 2'b00});
    end
    headFlags <= 5'h10;
    rx(ADDR_RECEIVE_HOLDING, 8'h00);
    rx(ADDR_LINE_STATUS, 8'ha0);
    rx(ADDR_LINE_STATUS, 8'ha0);
    headFlags <= '0;
    rx(ADDR_RECEIVE_HOLDING, 8'h00);
    rx(ADDR_LINE_STATUS, 8'h80);
    rxFull <= 1'b1;
    rxCharValid <= 1'b1;
    tick(1);
    {rxFull, rxCharValid} <= 2'b00;
    rx(ADDR_LINE_STATUS, 8'h82);
    rx(ADDR_INTERRUPT_STATUS, 8'h01);
    $display("test line_flags done");
    secondaryPending <= 1'b1;
    specialCharEvent <= 1'b1;
    triggerLevel <= 8'hf1;
    txLevel <= 8'd8;
    tick(1);
    specialCharEvent <= 1'b0;
    tick(3);
    txLevel <= 8'd0;
    tick(2);
    rx(ADDR_INTERRUPT_STATUS, 8'h26);
    txLevel <= 8'd8;
    rx(ADDR_INTERRUPT_STATUS, 8'h10);
    rx(ADDR_INTERRUPT_STATUS, 8'h00);
    secondaryPending <= 1'b0;
    txLevel <= 8'd0;
    irqEnable <= 8'h80;
    ctsPin <= 1'b0;
    tick(5);
    irqEnable <= 8'h00;
    #1 chk("irqN", 8'h00, {7'h00, irqN});
    tick(2);
    #1 chk("irqN", 8'h01, {7'h00, irqN});
    rx(ADDR_INTERRUPT_STATUS, 8'ha0);
    $display("test sources_irq done");
    rxLevel <= 8'd1;
    timeoutPeriod <= 8'h03;
    pulses(6);
    rx(ADDR_LINE_STATUS, 8'h03);
    timeoutPeriod <= 8'h00;
    rx(ADDR_RECEIVE_HOLDING, 8'h00);
    pulses(6);
    rx(ADDR_LINE_STATUS, 8'h00);
    rxLevel <= 8'd0;
    rxTrigInvert <= 1'b1;
    tick(2);
    rx(ADDR_INTERRUPT_STATUS, 8'h49);
    clkEn <= 1'b0;
    ctsPin <= 1'b1;
    tick(4);
    clkEn <= 1'b1;
    rx(ADDR_LINE_STATUS, 8'h00);
    rx(ADDR_LINE_STATUS, 8'h80);
    $display("test timeout_levels done");
    tick(3);
    summarize();
  end
endmodule // tb_uart_interrupt_line_status

// >>> verification/uils_host_model.sv
// Purpose: host side of the register port, one byte per strobe
// Assumes: strobes launched just after a rising edge
// Notes:   released lines show inverted values so stale data never passes
`timescale 1ns/1ps

module uils_host_model
(
  // clock
  input  wire logic       mclk,
  // register port
  output logic      [7:0] regAddr,
  output logic            regRd,
  output logic            regWr,
  output logic      [7:0] regWdata
);
  initial
  begin
    regAddr  = 8'h00;
    regRd    = 1'b0;
    regWr    = 1'b0;
    regWdata = 8'h00;
  end

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd   <= 1'b0;
    regAddr <= ~a;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr    <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask
endmodule // uils_host_model
